// *** rtl/ppc_port.sv ***
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - a pull-down is applied only on an interrupt pin whose polarity selects rising edge.
// - direction and pull enable are ignored for pin 4, which always drives.
// - slew bits 7:6,4:0 enable slew limiting on output pins only.
// - bit 5 of the slew and drive registers ignores writes and reads zero here.
// - drive bits 7:6,4:0 pick high drive when set, on output pins only.
// - the flag in bit 3 is set by detection and is untouched by direct writes.
// - writing 1 to bit 2 requests a flag clear and bit 2 reads 0.
// - bit 1 gates the flag onto the interrupt request.
// - bit 0 selects edge-only or edge-and-level detection.
// - only pins with their select bit set feed the flag.
// - polarity 0 means falling/low with pull-up, 1 means rising/high, with pull-down only on a selected pin.
// - pull enables act only on input pins, plus the open-drain pin 5.
module ppc_port
   import ppc_pkg::*;
#(
   parameter int WIDTH = PPC_WIDTH
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // pins
   input  wire logic [WIDTH-1:0] pin_in,
   // pad controls
   output logic      [WIDTH-1:0] pad_output_en,
   output logic      [WIDTH-1:0] pad_pull_up,
   output logic      [WIDTH-1:0] pad_pull_down,
   output logic      [WIDTH-1:0] pad_slew_limit,
   output logic      [WIDTH-1:0] pad_high_drive,
   // interrupts
   output logic                  pin_irq_req,
   output logic                  irq
);
   logic [WIDTH-1:0] slew_limit_bits;
   logic [WIDTH-1:0] drive_strength_bits;
   logic [WIDTH-1:0] pin_irq_source_select;
   logic [WIDTH-1:0] pin_irq_polarity_select;
   logic [WIDTH-1:0] direction_bits;
   logic [WIDTH-1:0] pull_enable_bits;
   logic             pin_irq_flag;
   logic             pin_irq_enable;
   logic             pin_irq_detect_mode;
   logic [PPC_EVT_NUM-1:0] evt_status;
   logic [PPC_EVT_NUM-1:0] evt_mask;
   logic [31:0]      rdata_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [WIDTH-1:0] one_hot(input int idx);
      one_hot      = '0;
      one_hot[idx] = 1'b1;
   endfunction

   wire access   = psel & penable & ce;
   wire wr       = access & pwrite;
   wire rd       = access & ~pwrite;
   wire wr_slew  = wr & hit(paddr, PPC_OFF_SLEW);
   wire wr_drive = wr & hit(paddr, PPC_OFF_DRIVE);
   wire wr_sc    = wr & hit(paddr, PPC_OFF_SC);
   wire wr_ps    = wr & hit(paddr, PPC_OFF_PS);
   wire wr_es    = wr & hit(paddr, PPC_OFF_ES);
   wire wr_dir   = wr & hit(paddr, PPC_OFF_DIR);
   wire wr_pull  = wr & hit(paddr, PPC_OFF_PULL);
   wire wr_mask  = wr & hit(paddr, PPC_OFF_MASK);
   wire rd_evt   = rd & hit(paddr, PPC_OFF_EVT);
   wire mapped   = hit(paddr, PPC_OFF_SLEW) | hit(paddr, PPC_OFF_DRIVE)
                 | hit(paddr, PPC_OFF_SC) | hit(paddr, PPC_OFF_PS)
                 | hit(paddr, PPC_OFF_ES) | hit(paddr, PPC_OFF_DIR)
                 | hit(paddr, PPC_OFF_PULL) | hit(paddr, PPC_OFF_EVT)
                 | hit(paddr, PPC_OFF_MASK);

   logic [WIDTH-1:0] edge_hit;
   logic [WIDTH-1:0] level_hit;

   ppc_edge_detect #(.WIDTH(WIDTH)) u_detect (
      .pclk          (pclk),
      .presetn       (presetn),
      .ce            (ce),
      .pin_in        (pin_in),
      .source_select (pin_irq_source_select),
      .polarity      (pin_irq_polarity_select),
      .edge_hit      (edge_hit),
      .level_hit     (level_hit)
   );

   ppc_pad_ctrl #(.WIDTH(WIDTH)) u_pad (
      .direction      (direction_bits),
      .pull_enable    (pull_enable_bits),
      .slew           (slew_limit_bits),
      .drive          (drive_strength_bits),
      .source_select  (pin_irq_source_select),
      .polarity       (pin_irq_polarity_select),
      .pad_output_en  (pad_output_en),
      .pad_pull_up    (pad_pull_up),
      .pad_pull_down  (pad_pull_down),
      .pad_slew_limit (pad_slew_limit),
      .pad_high_drive (pad_high_drive)
   );

   // detection per mode
   wire detect    = (|edge_hit) | (pin_irq_detect_mode & (|level_hit));
   wire ack       = wr_sc & pwdata[PPC_SC_ACK];
   wire level_hold = pin_irq_detect_mode & (|level_hit);
   wire next_flag = detect | level_hold | (pin_irq_flag & ~ack);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_irq_flag <= 1'b0;
      end else if (ce) begin
         pin_irq_flag <= next_flag;
      end
   end

   // control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slew_limit_bits         <= PPC_RST_ZERO;
         drive_strength_bits     <= PPC_RST_ZERO;
         pin_irq_source_select   <= PPC_RST_ZERO;
         pin_irq_polarity_select <= PPC_RST_ZERO;
         direction_bits          <= PPC_RST_ZERO;
         pull_enable_bits        <= PPC_RST_ZERO;
         pin_irq_enable          <= 1'b0;
         pin_irq_detect_mode     <= 1'b0;
         evt_mask                <= '0;
      end else begin
         if (wr_slew) begin
            slew_limit_bits <= pwdata[WIDTH-1:0] & PPC_PAD_MASK;
         end
         if (wr_drive) begin
            drive_strength_bits <= pwdata[WIDTH-1:0] & PPC_PAD_MASK;
         end
         if (wr_ps) begin
            pin_irq_source_select <= pwdata[WIDTH-1:0];
         end
         if (wr_es) begin
            pin_irq_polarity_select <= pwdata[WIDTH-1:0] & PPC_POL_MASK;
         end
         if (wr_dir) begin
            direction_bits <= pwdata[WIDTH-1:0];
         end
         if (wr_pull) begin
            pull_enable_bits <= pwdata[WIDTH-1:0];
         end
         if (wr_sc) begin
            pin_irq_enable      <= pwdata[PPC_SC_IE];
            pin_irq_detect_mode <= pwdata[PPC_SC_MOD];
         end
         if (wr_mask) begin
            evt_mask <= pwdata[PPC_EVT_NUM-1:0];
         end
      end
   end

   // sticky event: set on flag rise, clear on read, set wins
   wire flag_rise = next_flag & ~pin_irq_flag & ce;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_status <= '0;
      end else if (flag_rise) begin
         evt_status[PPC_EVT_FLAG] <= 1'b1;
      end else if (rd_evt) begin
         evt_status <= '0;
      end
   end

   // read mux
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      case (paddr)
         PPC_OFF_SLEW:  next_rdata[WIDTH-1:0] = slew_limit_bits;
         PPC_OFF_DRIVE: next_rdata[WIDTH-1:0] = drive_strength_bits;
         PPC_OFF_SC: begin
            next_rdata[PPC_SC_FLAG] = pin_irq_flag;
            next_rdata[PPC_SC_ACK]  = 1'b0;
            next_rdata[PPC_SC_IE]   = pin_irq_enable;
            next_rdata[PPC_SC_MOD]  = pin_irq_detect_mode;
         end
         PPC_OFF_PS:    next_rdata[WIDTH-1:0] = pin_irq_source_select;
         PPC_OFF_ES:    next_rdata[WIDTH-1:0] = pin_irq_polarity_select;
         PPC_OFF_DIR:   next_rdata[WIDTH-1:0] = direction_bits;
         PPC_OFF_PULL:  next_rdata[WIDTH-1:0] = pull_enable_bits;
         PPC_OFF_EVT:   next_rdata[PPC_EVT_NUM-1:0] = evt_status;
         PPC_OFF_MASK:  next_rdata[PPC_EVT_NUM-1:0] = evt_mask;
         default:       next_rdata = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (ce & psel & ~penable & ~pwrite) begin
         rdata_q <= next_rdata;
      end
   end

   assign prdata      = rdata_q;
   assign pready      = ce;
   assign pslverr     = psel & penable & ~mapped;
   assign pin_irq_req = pin_irq_flag & pin_irq_enable;
   assign irq         = |(evt_status & evt_mask);

   // assertion helpers
   wire [WIDTH-1:0] pull_any = pad_pull_up | pad_pull_down;
   wire [WIDTH-1:0] od_bit   = one_hot(PPC_PIN_OPEN_DRN);

   // steps of the flag and event path
   sequence s_flag_rise;
      ce && !pin_irq_flag && next_flag;
   endsequence

   sequence s_ack_quiet;
      ce && ack && !detect && !level_hold;
   endsequence

   sequence s_ack_hit;
      ce && ack && detect;
   endsequence

   // assertions
   a_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd & hit(paddr, PPC_OFF_SC) |-> !prdata[PPC_SC_ACK])
      else $error("ack bit read back as one");

   a_req_gated_ie: assert property (@(posedge pclk) disable iff (!presetn)
      pin_irq_req |-> pin_irq_flag && pin_irq_enable)
      else $error("request without flag and enable");

   a_flag_write_safe: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_sc && !pwdata[PPC_SC_ACK] && pin_irq_flag |=> pin_irq_flag)
      else $error("direct write changed flag");

   a_edge_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && (|edge_hit) |=> pin_irq_flag)
      else $error("edge did not set flag");

   a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
      ce && pin_irq_detect_mode && (|level_hit) && ack |=> pin_irq_flag)
      else $error("ack cleared flag while level active");

   a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
      s_ack_quiet |=> !pin_irq_flag)
      else $error("ack did not clear flag");

   a_edge_mode_nolevel: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !pin_irq_detect_mode && !(|edge_hit) && ack |=> !pin_irq_flag)
      else $error("level set flag in edge mode");

   a_out4_no_pull: assert property (@(posedge pclk) disable iff (!presetn)
      pad_output_en[PPC_PIN_OUT_ONLY] && !pad_pull_up[PPC_PIN_OUT_ONLY]
      && !pad_pull_down[PPC_PIN_OUT_ONLY])
      else $error("pin four not a plain output");

   a_pulldown_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (pad_pull_down & ~(pin_irq_source_select & pin_irq_polarity_select)) == '0)
      else $error("pull-down without rising select");

   a_bit5_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !slew_limit_bits[PPC_PIN_OPEN_DRN] && !drive_strength_bits[PPC_PIN_OPEN_DRN])
      else $error("bit five stored");

   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      s_ack_hit |=> pin_irq_flag)
      else $error("ack beat a detection in the same cycle");

   a_flag_needs_cause: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !pin_irq_flag && !detect |=> !pin_irq_flag)
      else $error("flag set without detection");

   a_level_sets: assert property (@(posedge pclk) disable iff (!presetn)
      ce && pin_irq_detect_mode && (|level_hit) |=> pin_irq_flag)
      else $error("active level did not set flag");

   a_pin_select_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ((edge_hit | level_hit) & ~pin_irq_source_select) == '0)
      else $error("unselected pin reported a hit");

   a_no_req_ie_off: assert property (@(posedge pclk) disable iff (!presetn)
      !pin_irq_enable |-> !pin_irq_req)
      else $error("request while interrupt disabled");

   a_slew_outputs_only: assert property (@(posedge pclk) disable iff (!presetn)
      (pad_slew_limit & ~pad_output_en) == '0)
      else $error("slew limit on an input pin");

   a_drive_outputs_only: assert property (@(posedge pclk) disable iff (!presetn)
      (pad_high_drive & ~pad_output_en) == '0)
      else $error("high drive on an input pin");

   a_pull_inputs_only: assert property (@(posedge pclk) disable iff (!presetn)
      (pull_any & pad_output_en & ~od_bit) == '0)
      else $error("pull device on an output pin");

   a_od_pull_kept: assert property (@(posedge pclk) disable iff (!presetn)
      pull_enable_bits[PPC_PIN_OPEN_DRN] |-> pull_any[PPC_PIN_OPEN_DRN])
      else $error("open-drain pin lost its pull");

   a_pull_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
      (pull_any & ~pull_enable_bits) == '0)
      else $error("pull device without enable");

   a_pull_one_kind: assert property (@(posedge pclk) disable iff (!presetn)
      (pad_pull_up & pad_pull_down) == '0)
      else $error("pull-up and pull-down together");

   a_pol_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (pin_irq_polarity_select & ~PPC_POL_MASK) == '0)
      else $error("polarity stored above bit three");

   a_evt_from_rise: assert property (@(posedge pclk) disable iff (!presetn)
      s_flag_rise |=> evt_status[PPC_EVT_FLAG])
      else $error("flag rise not recorded as event");

   a_evt_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
      rd_evt && !flag_rise |=> evt_status == '0)
      else $error("event read did not clear status");

   a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> $stable(pin_irq_flag) && $stable(evt_status) && $stable(prdata)
      && $stable(pin_irq_enable))
      else $error("state moved while clock enable low");

   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !mapped |-> pslverr)
      else $error("unmapped access not refused");
endmodule
`default_nettype wire

// *** rtl/ppc_pkg.sv ***
package ppc_pkg;
   localparam int PPC_WIDTH = 8;
   // register byte addresses
   localparam logic [7:0] PPC_OFF_SLEW    = 8'h00;
   localparam logic [7:0] PPC_OFF_DRIVE   = 8'h04;
   localparam logic [7:0] PPC_OFF_SC      = 8'h08;
   localparam logic [7:0] PPC_OFF_PS      = 8'h0c;
   localparam logic [7:0] PPC_OFF_ES      = 8'h10;
   localparam logic [7:0] PPC_OFF_DIR     = 8'h14;
   localparam logic [7:0] PPC_OFF_PULL    = 8'h18;
   localparam logic [7:0] PPC_OFF_EVT     = 8'h1c;
   localparam logic [7:0] PPC_OFF_MASK    = 8'h20;
   // status/control field positions
   localparam int PPC_SC_FLAG = 3;
   localparam int PPC_SC_ACK  = 2;
   localparam int PPC_SC_IE   = 1;
   localparam int PPC_SC_MOD  = 0;
   // pin roles
   localparam int PPC_PIN_OUT_ONLY  = 4;
   localparam int PPC_PIN_OPEN_DRN  = 5;
   // implemented bits of slew/drive regs (bit 5 absent)
   localparam logic [7:0] PPC_PAD_MASK    = 8'hdf;
   // polarity register implemented bits 3:0
   localparam logic [7:0] PPC_POL_MASK    = 8'h0f;
   localparam logic [7:0] PPC_RST_ZERO    = 8'h00;
   // event status bits
   localparam int PPC_EVT_FLAG = 0;
   localparam int PPC_EVT_NUM  = 1;
endpackage

// *** rtl/ppc_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
// per-pin edge and level detection
module ppc_edge_detect
   import ppc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // pins and config
   input  wire logic [WIDTH-1:0] pin_in,
   input  wire logic [WIDTH-1:0] source_select,
   input  wire logic [WIDTH-1:0] polarity,
   // results
   output logic      [WIDTH-1:0] edge_hit,
   output logic      [WIDTH-1:0] level_hit
);
   logic [WIDTH-1:0] sync1;
   logic [WIDTH-1:0] sync2;
   logic [WIDTH-1:0] prev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= '0;
         sync2 <= '0;
         prev  <= '0;
      end else if (ce) begin
         sync1 <= pin_in;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_pin
         // active level per polarity
         wire active_now  = polarity[g] ? sync2[g] : ~sync2[g];
         wire active_prev = polarity[g] ? prev[g]  : ~prev[g];
         assign edge_hit[g]  = source_select[g] & active_now & ~active_prev;
         assign level_hit[g] = source_select[g] & active_now;
      end
   endgenerate
endmodule
`default_nettype wire

// *** rtl/ppc_pad_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// pad enables derived from config
module ppc_pad_ctrl
   import ppc_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // config
   input  wire logic [WIDTH-1:0] direction,
   input  wire logic [WIDTH-1:0] pull_enable,
   input  wire logic [WIDTH-1:0] slew,
   input  wire logic [WIDTH-1:0] drive,
   input  wire logic [WIDTH-1:0] source_select,
   input  wire logic [WIDTH-1:0] polarity,
   // pad controls
   output logic      [WIDTH-1:0] pad_output_en,
   output logic      [WIDTH-1:0] pad_pull_up,
   output logic      [WIDTH-1:0] pad_pull_down,
   output logic      [WIDTH-1:0] pad_slew_limit,
   output logic      [WIDTH-1:0] pad_high_drive
);
   logic [WIDTH-1:0] is_out;
   logic [WIDTH-1:0] pull_on;
   logic [WIDTH-1:0] want_down;
   always_comb begin
      is_out = direction;
      is_out[PPC_PIN_OUT_ONLY] = 1'b1;
      pull_on = pull_enable & ~is_out;
      pull_on[PPC_PIN_OPEN_DRN] = pull_enable[PPC_PIN_OPEN_DRN];
      pull_on[PPC_PIN_OUT_ONLY] = 1'b0;
      want_down = source_select & polarity;
   end
   assign pad_output_en  = is_out;
   assign pad_pull_down  = pull_on & want_down;
   assign pad_pull_up    = pull_on & ~want_down;
   assign pad_slew_limit = slew & is_out & PPC_PAD_MASK;
   assign pad_high_drive = drive & is_out & PPC_PAD_MASK;
endmodule
`default_nettype wire

// *** test/ppc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// external pins: driven where drv is set, else pulled or floating
module ppc_pin_model (
   // clock
   input  wire logic       pclk,
   // stimulus
   input  wire logic [7:0] drv,
   input  wire logic [7:0] level,
   // pad pulls seen from the device
   input  wire logic [7:0] pad_pull_up,
   input  wire logic [7:0] pad_pull_down,
   // pins
   output logic      [7:0] pin_in
);
   // a floating pin flips each cycle so it never reads as a stable level
   initial pin_in = 8'h00;
   always @(posedge pclk) begin
      pin_in <= (drv & level) | (~drv & (pad_pull_up | (~pad_pull_down & ~pin_in)));
   end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ppc_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_irq_req, irq;
   logic [7:0]  paddr, lvl, pin_in, oe, pu, pd, slew, drive;
   logic [31:0] pwdata, prdata, q;
   logic        e, ce;
   event        hang;
   int          errors, n_tests;

   ppc_port ppc_port_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pad_output_en(oe),
      .pad_pull_up(pu), .pad_pull_down(pd), .pad_slew_limit(slew), .pad_high_drive(drive),
      .pin_irq_req(pin_irq_req), .irq(irq));
   ppc_pin_model ppc_pin_model_inst (.pclk(pclk), .drv(8'h03), .level(lvl),
      .pad_pull_up(pu), .pad_pull_down(pd), .pin_in(pin_in));

   initial pclk = 1'b0;
   always #50 pclk = ~pclk;

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         -> hang;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, {24'h0, exp});
   endtask

   task automatic settle;
      @(negedge pclk);
   endtask

   // bounded wait for an interrupt line at the falling edge
   task automatic wt(input logic sel);
      int n;
      for (n = 0; n < 20 && (sel ? irq : pin_irq_req) !== 1'b1; n++) begin
         @(negedge pclk);
      end
      chk((sel ? irq : pin_irq_req), 1'b1);
   endtask

   // overall limit, or a bus wait that ran out
   initial begin
      fork
         #(100 * 20000);
         @(hang);
      join_any
      errors++;
      give_verdict();
   end

   initial begin
      errors = 0; n_tests = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; lvl = 8'h00;
      ce = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(PPC_OFF_SLEW, 8'h00);
      rd(PPC_OFF_DRIVE, 8'h00);
      rd(PPC_OFF_SC, 8'h00);
      rd(PPC_OFF_PS, 8'h00);
      rd(PPC_OFF_ES, 8'h00);
      rd(PPC_OFF_DIR, 8'h00);
      rd(PPC_OFF_PULL, 8'h00);
      rd(PPC_OFF_EVT, 8'h00);
      rd(PPC_OFF_MASK, 8'h00);
      chk(oe, 8'h10);
      $display("test reset values done");
      wr(PPC_OFF_SLEW, 8'hff);
      wr(PPC_OFF_DRIVE, 8'hff);
      rd(PPC_OFF_SLEW, 8'hdf);
      rd(PPC_OFF_DRIVE, 8'hdf);
      settle;
      chk(slew, 8'h10);
      chk(drive, 8'h10);
      wr(PPC_OFF_DIR, 8'hef);
      wr(PPC_OFF_PULL, 8'hff);
      settle;
      chk(oe, 8'hff);
      chk(slew, 8'hdf);
      chk(drive, 8'hdf);
      chk(pu, 8'h20);
      wr(PPC_OFF_DIR, 8'h00);
      settle;
      chk(pu, 8'hef);
      chk(pd, 8'h00);
      $display("test pad controls done");
      // software bring-up order for the pin interrupt
      wr(PPC_OFF_SC, 8'h00);
      wr(PPC_OFF_ES, 8'hff);
      wr(PPC_OFF_PULL, 8'h03);
      wr(PPC_OFF_PS, 8'h01);
      wr(PPC_OFF_SC, 8'h04);
      wr(PPC_OFF_SC, 8'h02);
      rd(PPC_OFF_ES, 8'h0f);
      settle;
      chk(pd, 8'h01);
      chk(pu, 8'h02);
      chk(pin_irq_req, 1'b0);
      lvl <= 8'h02;
      repeat (6) @(posedge pclk);
      rd(PPC_OFF_SC, 8'h02);
      lvl <= 8'h03;
      wt(1'b0);
      rd(PPC_OFF_SC, 8'h0a);
      wr(PPC_OFF_SC, 8'h02);
      rd(PPC_OFF_SC, 8'h0a);
      wr(PPC_OFF_SC, 8'h06);
      rd(PPC_OFF_SC, 8'h02);
      wr(PPC_OFF_SC, 8'h0a);
      rd(PPC_OFF_SC, 8'h02);
      settle;
      chk(pin_irq_req, 1'b0);
      lvl <= 8'h02;
      repeat (6) @(posedge pclk);
      rd(PPC_OFF_SC, 8'h02);
      wr(PPC_OFF_SC, 8'h00);
      lvl <= 8'h03;
      repeat (6) @(posedge pclk);
      rd(PPC_OFF_SC, 8'h08);
      settle;
      chk(pin_irq_req, 1'b0);
      $display("test edge mode done");
      wr(PPC_OFF_SC, 8'h07);
      rd(PPC_OFF_SC, 8'h0b);
      wr(PPC_OFF_SC, 8'h07);
      rd(PPC_OFF_SC, 8'h0b);
      lvl <= 8'h02;
      repeat (6) @(posedge pclk);
      wr(PPC_OFF_SC, 8'h07);
      rd(PPC_OFF_SC, 8'h03);
      $display("test level mode done");
      rd(PPC_OFF_EVT, 8'h01);
      rd(PPC_OFF_EVT, 8'h00);
      wr(PPC_OFF_MASK, 8'h01);
      settle;
      chk(irq, 1'b0);
      lvl <= 8'h03;
      wt(1'b1);
      wr(PPC_OFF_MASK, 8'h00);
      settle;
      chk(irq, 1'b0);
      wr(PPC_OFF_MASK, 8'h01);
      settle;
      chk(irq, 1'b1);
      rd(PPC_OFF_EVT, 8'h01);
      settle;
      chk(irq, 1'b0);
      // falling-edge polarity on pin 1
      wr(PPC_OFF_SC, 8'h00);
      wr(PPC_OFF_ES, 8'h0d);
      wr(PPC_OFF_PS, 8'h02);
      wr(PPC_OFF_SC, 8'h04);
      rd(PPC_OFF_SC, 8'h00);
      settle;
      chk(pd, 8'h00);
      chk(pu, 8'h03);
      lvl <= 8'h01;
      repeat (6) @(posedge pclk);
      rd(PPC_OFF_SC, 8'h08);
      ce <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(pready, 1'b0);
      ce <= 1'b1;
      @(posedge pclk);
      chk(pready, 1'b1);
      $display("test falling edge and clock enable done");
      apb(1'b0, 8'h40, 32'h0);
      chk(e, 1'b1);
      chk(q, 32'h0);
      $display("test events and refusal done");
      give_verdict();
   end
endmodule
`default_nettype wire
